// ==== dv/pofcl_flash_model.sv ====
// Behavioural flash partner for the loader: word memory with request-acknowledge port.
// Assumes the bench fills the memory by hierarchical poke and sets latency and the faulty address.
`timescale 1ns/100ps
`default_nettype none
module pofcl_flash_model
    import pofcl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Flash port
    input wire pofcl_pkg::pofcl_flash_req_t flash_req,
    output pofcl_pkg::pofcl_flash_rsp_t flash_rsp,
    // Behaviour controls
    input wire logic [1:0] lat,
    input wire logic [15:0] err_addr
);
    logic [15:0] mem [0:511];
    logic [1:0] wait_ff;
    logic ack_ff;
    logic err_ff;
    logic [15:0] rdata_ff;

    // Data shows the inverse of the last word whenever no answer is due
    assign flash_rsp = '{ack: ack_ff, err: err_ff, rdata: ack_ff ? rdata_ff : ~rdata_ff};

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            wait_ff <= 2'h0;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            if (flash_req.req && !ack_ff)
            begin
                if (wait_ff < lat)
                    wait_ff <= wait_ff + 2'h1;
                else
                begin
                    wait_ff <= 2'h0;
                    ack_ff <= 1'b1;
                    err_ff <= (flash_req.addr == err_addr);
                    rdata_ff <= mem[flash_req.addr[8:0]];
                    // Saved calibration words survive to the next power-up
                    if (flash_req.wr && flash_req.addr != err_addr)
                        mem[flash_req.addr[8:0]] <= flash_req.wdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/pofcl_loader_bench.sv ====
// Self-checking bench for the loader with a flash partner and a randomly stalling image sink.
// Assumes the package map of constants, autoload word, image length and image base.
`timescale 1ns/100ps
`default_nettype none
module pofcl_loader_bench;
    import pofcl_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic sw = 1'b0;
    logic [1:0] usw = 2'h0;
    logic sreq = 1'b0;
    logic sref = 1'b0;
    logic run = 1'b0;
    logic img_rdy = 1'b0;
    logic [7:0] ssel = 8'h00;
    logic [15:0] sdata = 16'h0000;
    logic [15:0] ai = 16'h0000;
    logic [15:0] ao = 16'h0000;
    logic [15:0] errad = 16'hFFFF;
    logic [1:0] lat = 2'h0;
    pofcl_flash_req_t freq;
    pofcl_flash_rsp_t frsp;
    pofcl_dac_wr_t dac;
    wire logic sbusy, sdone, tmo, ivalid, hold, ldone, lerr, ncal;
    wire logic [15:0] refv, idata, ai_u, ao_o;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 32'h2e52;
    int bad = 0;
    int k;
    int refm [0:511];
    logic [15:0] dacq [$];
    logic [15:0] imgq [$];

    always #12.5 clock = ~clock;

    pofcl_loader i_pofcl_loader (.CLOCK(clock), .SYS_RST(sys_rst), .FLASH_LOAD_INHIBIT_SWITCH(sw),
        .UNUSED_SWITCH_A(usw[0]), .UNUSED_SWITCH_B(usw[1]), .FLASH_REQ(freq), .FLASH_RSP(frsp),
        .DAC_WR(dac), .CAL_SAVE_REQ(sreq), .CAL_SAVE_REF(sref), .CAL_SAVE_SEL(ssel),
        .CAL_SAVE_DATA(sdata), .CAL_SAVE_BUSY(sbusy), .CAL_SAVE_DONE(sdone), .CAL_RUN(run),
        .CAL_TIMEOUT(tmo), .REF_VALUE(refv), .IMG_VALID(ivalid), .IMG_DATA(idata),
        .IMG_READY(img_rdy), .LOGIC_HOLD(hold), .AI_IN(ai), .AI_TO_USER(ai_u),
        .AO_FROM_USER(ao), .AO_OUT(ao_o), .LOAD_DONE(ldone), .LOAD_ERROR(lerr),
        .CAL_NOT_GUARANTEED(ncal));

    pofcl_flash_model i_pofcl_flash_model (.clock(clock), .sys_rst(sys_rst), .flash_req(freq),
        .flash_rsp(frsp), .lat(lat), .err_addr(errad));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("mismatches %0d checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic hang;
        n_mismatch++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        conclude();
    endtask

    // Collects DAC writes and accepted image words; flags image words out of place
    always @(posedge clock)
    begin
        img_rdy <= 1'($random(seed));
        if (!sys_rst && dac.we)
            dacq.push_back({dac.sel, dac.value});
        if (!sys_rst && ivalid && img_rdy)
        begin
            imgq.push_back(idata);
            if (dacq.size() != 16 || hold !== 1'b1)
                bad++;
        end
    end

    // One power-up with the given switch, autoload word, image length and faulty address
    task automatic up(input logic s, input logic [15:0] al, input logic [15:0] len, input logic [15:0] ea);
        int i;
        int nc;
        logic go;
        sys_rst <= 1'b1;
        sw <= s;
        usw <= 2'($random(seed));
        errad <= ea;
        lat <= 2'($random(seed));
        refm[AUTOLOAD_ADDR] = al;
        refm[IMAGE_LEN_ADDR] = len;
        i_pofcl_flash_model.mem[AUTOLOAD_ADDR] = al;
        i_pofcl_flash_model.mem[IMAGE_LEN_ADDR] = len;
        repeat (4) @(posedge clock);
        dacq.delete();
        imgq.delete();
        bad = 0;
        sys_rst <= 1'b0;
        for (i = 0; i < 3000; i++)
        begin
            @(posedge clock);
            #1;
            if (ldone === 1'b1 || lerr === 1'b1)
                break;
        end
        if (i == 3000)
            hang();
        repeat (4) @(posedge clock);
        #1;
        nc = (ea < 16) ? ea : 16;
        go = !s && al == AUTOLOAD_EN_VAL && len != 0 && ea >= 16;
        chk(dacq.size(), nc);
        for (i = 0; i < nc; i++)
            chk(dacq[i], {i[7:0], refm[i][7:0]});
        chk(imgq.size(), go ? len : 0);
        for (i = 0; i < imgq.size(); i++)
            chk(imgq[i], refm[IMAGE_BASE + i]);
        chk(bad, 0);
        chk({ldone, lerr, hold}, (ea < 16) ? 3'b011 : 3'b100);
        chk(ncal, s);
    endtask

    // Saves a constant (with live calibration running) or the reference word
    task automatic sv(input logic r, input logic [7:0] s, input logic [15:0] d);
        int i;
        int a;
        a = r ? REF_ADDR : CONST_BASE + s;
        dacq.delete();
        sref <= r;
        ssel <= s;
        sdata <= d;
        sreq <= 1'b1;
        run <= !r;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clock);
            if (sbusy === 1'b1)
                break;
        end
        if (i == 50)
            hang();
        sreq <= 1'b0;
        for (i = 0; i < 300; i++)
        begin
            @(posedge clock);
            if (sdone === 1'b1)
                break;
        end
        if (i == 300)
            hang();
        run <= 1'b0;
        #1;
        refm[a] = d;
        chk(i_pofcl_flash_model.mem[a], refm[a]);
        chk(dacq.size(), !r);
        chk(r ? refv : dacq[0], r ? d : {s, d[7:0]});
        chk(tmo, 0);
    endtask

    initial
    begin
        for (k = 0; k < 512; k++)
        begin
            refm[k] = $random(seed) & 32'hFFFF;
            i_pofcl_flash_model.mem[k] = refm[k][15:0];
        end
        up(1'b0, 16'h0001, 16'h0004, 16'hFFFF);
        for (k = 0; k < 8; k++)
        begin
            @(posedge clock);
            ai <= 16'($random(seed));
            ao <= 16'($random(seed));
            @(posedge clock);
            #1;
            chk(ai_u, ai);
            chk(ao_o, ao);
        end
        sv(1'b0, 8'h03, 16'($random(seed)));
        sv(1'b1, 8'h00, 16'($random(seed)));
        up(1'b0, 16'h0001, 16'h0004, 16'hFFFF);
        up(1'b1, 16'h0001, 16'h0004, 16'hFFFF);
        up(1'b0, 16'h0000, 16'h0004, 16'hFFFF);
        up(1'b0, 16'h0002, 16'h0004, 16'hFFFF);
        up(1'b0, 16'h0001, 16'h0000, 16'hFFFF);
        up(1'b0, 16'h0001, 16'h0004, 16'h0005);
        up(1'b0, 16'h0001, 16'h0001, 16'hFFFF);
        conclude();
    end
endmodule
`default_nettype wire

// ==== logic/pofcl_loader.sv ====
// Power-on loader: constants from flash to correction DACs, then optional image load.
// Assumes flash answers each request with one ack pulse; image sink takes a word per valid.
`timescale 1ns/100ps
`default_nettype none
module pofcl_loader
    import pofcl_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // Board switches
    input wire logic FLASH_LOAD_INHIBIT_SWITCH,
    input wire logic UNUSED_SWITCH_A,
    input wire logic UNUSED_SWITCH_B,
    // Flash port
    output pofcl_pkg::pofcl_flash_req_t FLASH_REQ,
    input wire pofcl_pkg::pofcl_flash_rsp_t FLASH_RSP,
    // Correction DACs
    output pofcl_pkg::pofcl_dac_wr_t DAC_WR,
    // Calibration save request
    input wire logic CAL_SAVE_REQ,
    input wire logic CAL_SAVE_REF,
    input wire logic [7:0] CAL_SAVE_SEL,
    input wire logic [pofcl_pkg::DATA_W-1:0] CAL_SAVE_DATA,
    output logic CAL_SAVE_BUSY,
    output logic CAL_SAVE_DONE,
    input wire logic CAL_RUN,
    output logic CAL_TIMEOUT,
    output logic [pofcl_pkg::DATA_W-1:0] REF_VALUE,
    // Programmable logic configuration
    output logic IMG_VALID,
    output logic [pofcl_pkg::DATA_W-1:0] IMG_DATA,
    input wire logic IMG_READY,
    output logic LOGIC_HOLD,
    // Analog data pass-through
    input wire logic [pofcl_pkg::DATA_W-1:0] AI_IN,
    output logic [pofcl_pkg::DATA_W-1:0] AI_TO_USER,
    input wire logic [pofcl_pkg::DATA_W-1:0] AO_FROM_USER,
    output logic [pofcl_pkg::DATA_W-1:0] AO_OUT,
    // Status
    output logic LOAD_DONE,
    output logic LOAD_ERROR,
    output logic CAL_NOT_GUARANTEED
);
    import pofcl_pkg::*;

    pofcl_state_t state_ff, nxt_state;
    logic [7:0] idx_ff;
    logic [ADDR_W-1:0] img_cnt_ff, img_len_ff;
    logic inhibit_ff, autoload_ff, pend_ff, sw_seen_ff;
    logic [DATA_W-1:0] img_word_ff;
    logic img_have_ff;
    // One bit above 32 so the two-minute count is reachable
    logic [32:0] cal_cnt_ff;
    logic ack_ok;

    assign ack_ok = FLASH_RSP.ack && !FLASH_RSP.err;

    // Switch sampled once after reset release; unused switches never read
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            inhibit_ff <= 1'b1;
            sw_seen_ff <= 1'b0;
        end
        else if (!sw_seen_ff)
        begin
            inhibit_ff <= FLASH_LOAD_INHIBIT_SWITCH;
            sw_seen_ff <= 1'b1;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (sw_seen_ff) nxt_state = ST_RD_CONST;
            ST_RD_CONST:
                if (FLASH_RSP.ack && FLASH_RSP.err) nxt_state = ST_FAIL;
                else if (ack_ok && idx_ff == NUM_DACS - 8'h01) nxt_state = ST_RD_CFG;
            ST_RD_CFG:
                if (FLASH_RSP.ack && FLASH_RSP.err) nxt_state = ST_FAIL;
                else if (ack_ok) nxt_state = ST_RD_LEN;
            ST_RD_LEN:
                if (FLASH_RSP.ack && FLASH_RSP.err) nxt_state = ST_FAIL;
                else if (ack_ok)
                    nxt_state = (!inhibit_ff && autoload_ff && FLASH_RSP.rdata != '0) ? ST_IMAGE : ST_DONE;
            ST_IMAGE:
                if (FLASH_RSP.ack && FLASH_RSP.err) nxt_state = ST_FAIL;
                else if (img_cnt_ff == img_len_ff && !img_have_ff && !pend_ff) nxt_state = ST_DONE;
            ST_DONE: if (CAL_SAVE_REQ) nxt_state = ST_SAVE;
            ST_SAVE:
                if (FLASH_RSP.ack) nxt_state = FLASH_RSP.err ? ST_FAIL : ST_DONE;
            ST_FAIL: nxt_state = ST_FAIL;
            default: nxt_state = ST_FAIL;
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Flash requests: one outstanding word at a time
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            FLASH_REQ <= '0;
            pend_ff <= 1'b0;
        end
        else if (FLASH_RSP.ack)
        begin
            FLASH_REQ.req <= 1'b0;
            pend_ff <= 1'b0;
        end
        else if (!pend_ff)
        begin
            FLASH_REQ.wr <= 1'b0;
            FLASH_REQ.wdata <= '0;
            unique case (state_ff)
                ST_RD_CONST:
                begin
                    FLASH_REQ.req <= 1'b1;
                    FLASH_REQ.addr <= CONST_BASE + ADDR_W'(idx_ff);
                    pend_ff <= 1'b1;
                end
                ST_RD_CFG:
                begin
                    FLASH_REQ.req <= 1'b1;
                    FLASH_REQ.addr <= AUTOLOAD_ADDR;
                    pend_ff <= 1'b1;
                end
                ST_RD_LEN:
                begin
                    FLASH_REQ.req <= 1'b1;
                    FLASH_REQ.addr <= IMAGE_LEN_ADDR;
                    pend_ff <= 1'b1;
                end
                ST_IMAGE:
                    if (!img_have_ff && img_cnt_ff != img_len_ff)
                    begin
                        FLASH_REQ.req <= 1'b1;
                        FLASH_REQ.addr <= IMAGE_BASE + img_cnt_ff;
                        pend_ff <= 1'b1;
                    end
                ST_SAVE:
                begin
                    // Stored constants with select 0 to 15 are what the next power-on loads
                    FLASH_REQ.req <= 1'b1;
                    FLASH_REQ.wr <= 1'b1;
                    FLASH_REQ.addr <= CAL_SAVE_REF ? REF_ADDR : CONST_BASE + ADDR_W'(CAL_SAVE_SEL);
                    FLASH_REQ.wdata <= CAL_SAVE_DATA;
                    pend_ff <= 1'b1;
                end
                default: FLASH_REQ.req <= 1'b0;
            endcase
        end
    end

    // Constant index, config and DAC writes
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            idx_ff <= '0;
            autoload_ff <= 1'b0;
            img_len_ff <= '0;
            DAC_WR <= '0;
        end
        else
        begin
            DAC_WR.we <= 1'b0;
            if (state_ff == ST_RD_CONST && ack_ok)
            begin
                DAC_WR.we <= 1'b1;
                DAC_WR.sel <= idx_ff;
                DAC_WR.value <= FLASH_RSP.rdata[DAC_W-1:0];
                idx_ff <= idx_ff + 8'h01;
            end
            if (state_ff == ST_RD_CFG && ack_ok)
                autoload_ff <= (FLASH_RSP.rdata == AUTOLOAD_EN_VAL);
            if (state_ff == ST_RD_LEN && ack_ok)
                img_len_ff <= FLASH_RSP.rdata;
            if (state_ff == ST_DONE && CAL_SAVE_REQ && CAL_RUN && !CAL_SAVE_REF)
            begin
                // Live calibration adjustment of one DAC
                DAC_WR.we <= 1'b1;
                DAC_WR.sel <= CAL_SAVE_SEL;
                DAC_WR.value <= CAL_SAVE_DATA[DAC_W-1:0];
            end
        end
    end

    // Image streaming to the programmable logic
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            img_cnt_ff <= '0;
            img_word_ff <= '0;
            img_have_ff <= 1'b0;
        end
        else
        begin
            if (img_have_ff && IMG_READY)
                img_have_ff <= 1'b0;
            if (state_ff == ST_IMAGE && ack_ok)
            begin
                img_word_ff <= FLASH_RSP.rdata;
                img_have_ff <= 1'b1;
                img_cnt_ff <= img_cnt_ff + 16'h0001;
            end
        end
    end

    assign IMG_VALID = img_have_ff;
    assign IMG_DATA = img_word_ff;

    // Reference value tracking and calibration watchdog
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            REF_VALUE <= '0;
            cal_cnt_ff <= '0;
            CAL_TIMEOUT <= 1'b0;
            CAL_SAVE_DONE <= 1'b0;
        end
        else
        begin
            CAL_SAVE_DONE <= state_ff == ST_SAVE && ack_ok;
            if (state_ff == ST_SAVE && ack_ok && CAL_SAVE_REF)
                REF_VALUE <= FLASH_REQ.wdata;
            if (!CAL_RUN)
                cal_cnt_ff <= '0;
            else if (64'(cal_cnt_ff) < CAL_LIMIT_CYC)
                cal_cnt_ff <= cal_cnt_ff + 33'h0_0000_0001;
            CAL_TIMEOUT <= CAL_RUN && 64'(cal_cnt_ff) >= CAL_LIMIT_CYC;
        end
    end

    assign CAL_SAVE_BUSY = state_ff == ST_SAVE;

    // Analog data already corrected in hardware; forwarded unchanged
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            AI_TO_USER <= '0;
            AO_OUT <= '0;
        end
        else
        begin
            AI_TO_USER <= AI_IN;
            AO_OUT <= AO_FROM_USER;
        end
    end

    // Status outputs
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            LOGIC_HOLD <= 1'b1;
            LOAD_DONE <= 1'b0;
            LOAD_ERROR <= 1'b0;
            CAL_NOT_GUARANTEED <= 1'b0;
        end
        else
        begin
            LOGIC_HOLD <= !(nxt_state == ST_DONE || nxt_state == ST_SAVE);
            LOAD_DONE <= nxt_state == ST_DONE || nxt_state == ST_SAVE;
            LOAD_ERROR <= nxt_state == ST_FAIL;
            CAL_NOT_GUARANTEED <= sw_seen_ff && inhibit_ff;
        end
    end

    dac_before_img_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (state_ff == ST_IMAGE) |-> idx_ff == NUM_DACS) else $error("image before constants");
    inhibit_blocks_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        inhibit_ff && sw_seen_ff |-> state_ff != ST_IMAGE) else $error("image with inhibit");
    autoload_need_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $rose(state_ff == ST_IMAGE) |-> autoload_ff && !inhibit_ff) else $error("image without both");
    allow_load_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        state_ff == ST_RD_LEN && ack_ok && !inhibit_ff && autoload_ff && FLASH_RSP.rdata != '0
        |=> state_ff == ST_IMAGE) else $error("allowed image not loaded");
    hold_done_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        LOAD_DONE |-> !LOGIC_HOLD && !LOAD_ERROR) else $error("done while held");
    no_correct_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> AI_TO_USER == $past(AI_IN) && AO_OUT == $past(AO_FROM_USER))
        else $error("analog data altered");
    not_guar_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        sw_seen_ff && inhibit_ff |=> CAL_NOT_GUARANTEED) else $error("flag missing");
    save_write_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        state_ff == ST_SAVE && FLASH_REQ.req |-> FLASH_REQ.wr) else $error("save not a write");
    ref_saved_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        state_ff == ST_SAVE && ack_ok && CAL_SAVE_REF |=> REF_VALUE == $past(FLASH_REQ.wdata))
        else $error("reference not kept");

    load_image_c: cover property (@(posedge CLOCK) disable iff (SYS_RST) state_ff == ST_IMAGE ##[1:1000] LOAD_DONE);
    inhibit_c: cover property (@(posedge CLOCK) disable iff (SYS_RST) inhibit_ff && sw_seen_ff ##[1:200] LOAD_DONE);
    save_c: cover property (@(posedge CLOCK) disable iff (SYS_RST) CAL_SAVE_DONE);
    fail_c: cover property (@(posedge CLOCK) disable iff (SYS_RST) LOAD_ERROR);
endmodule
`default_nettype wire

// ==== shared/pofcl_pkg.sv ====
// Constants and carrier types for the power-on flash configuration loader.
// Assumes a flash with a simple word read/write request-acknowledge port.
package pofcl_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int DAC_W = 8;
    localparam logic [7:0] NUM_DACS = 8'h10;
    localparam logic [ADDR_W-1:0] CONST_BASE = 16'h0000;
    localparam logic [ADDR_W-1:0] REF_ADDR = 16'h0040;
    localparam logic [ADDR_W-1:0] AUTOLOAD_ADDR = 16'h0041;
    localparam logic [ADDR_W-1:0] IMAGE_LEN_ADDR = 16'h0042;
    localparam logic [ADDR_W-1:0] IMAGE_BASE = 16'h0100;
    localparam logic [DATA_W-1:0] AUTOLOAD_EN_VAL = 16'h0001;
    localparam int CLK_HZ = 40_000_000;
    localparam int CAL_LIMIT_S = 120;
    localparam longint CAL_LIMIT_CYC = longint'(CLK_HZ) * CAL_LIMIT_S;

    typedef struct packed {
        logic req;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pofcl_flash_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [DATA_W-1:0] rdata;
    } pofcl_flash_rsp_t;

    typedef struct packed {
        logic we;
        logic [7:0] sel;
        logic [DAC_W-1:0] value;
    } pofcl_dac_wr_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_RD_CONST = 8'h02,
        ST_RD_CFG = 8'h04,
        ST_RD_LEN = 8'h08,
        ST_IMAGE = 8'h10,
        ST_DONE = 8'h20,
        ST_SAVE = 8'h40,
        ST_FAIL = 8'h80
    } pofcl_state_t;
endpackage
